// ### pkg/mpt_pkg.sv
// Package for the multi-channel PWM timer: register map, fields, resets
package mpt_pkg;
  localparam int unsigned NUM_MATCH = 7;
  localparam int unsigned NUM_OUT   = 6;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_PRESCALE = 8'h04;
  localparam logic [7:0] ADDR_PRECOUNT = 8'h08;
  localparam logic [7:0] ADDR_COUNT    = 8'h0c;
  localparam logic [7:0] ADDR_MATCHCTL = 8'h10;
  localparam logic [7:0] ADDR_OUTCTL   = 8'h14;
  localparam logic [7:0] ADDR_RELEASE  = 8'h18;
  localparam logic [7:0] ADDR_INTSTAT  = 8'h1c;
  localparam logic [7:0] ADDR_INTMASK  = 8'h20;
  localparam logic [7:0] ADDR_MATCH0   = 8'h40;
  // Control bits
  localparam int unsigned CTRL_RUN_BIT   = 0;
  localparam int unsigned CTRL_RESET_BIT = 1;
  localparam int unsigned CTRL_PWM_BIT   = 2;
  // Match control: three bits per match (irq, reset, stop)
  localparam int unsigned MC_IRQ   = 0;
  localparam int unsigned MC_RESET = 1;
  localparam int unsigned MC_STOP  = 2;
  // Output control: bits 2..6 double-edge select (bit 1 has no effect), bits 9..14 enables
  localparam int unsigned OC_DBL_LSB = 1;
  localparam int unsigned OC_EN_LSB  = 9;
  localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
  } mpt_req_t;
endpackage : mpt_pkg

// ### rtl/mpt_timer.sv
// Multi-channel PWM timer with AXI4-Lite register slave
`timescale 1ns/10ps
`default_nettype none
module mpt_timer
  import mpt_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [mpt_pkg::NUM_OUT:1] pwm_out,
  output logic                      irq
);
  import mpt_pkg::*;

  logic [31:0]          ctrl_q, prescale_q, precnt_q, count_q, matchctl_q, outctl_q;
  logic [NUM_MATCH-1:0] release_q, istat_q, imask_q;
  logic [31:0]          shadow_q [NUM_MATCH];
  logic [31:0]          active_q [NUM_MATCH];
  logic [NUM_OUT:1]     pwm_q;

  // Write channel: address and data held until both present
  mpt_req_t    aw_q;
  logic        w_have_q, b_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        ar_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q, bresp_q;

  wire take_aw = s_axi_awvalid && s_axi_awready;
  wire take_w  = s_axi_wvalid && s_axi_wready;
  wire do_wr   = aw_q.valid && w_have_q && !b_q;
  wire [7:0] wa = aw_q.addr;
  // Readies come from flops; next values mirror the handshake state
  logic        awrdy_q, wrdy_q, arrdy_q;
  wire aw_busy_d = take_aw || (aw_q.valid && !do_wr);
  wire w_busy_d  = take_w || (w_have_q && !do_wr);
  wire b_d       = do_wr || (b_q && !s_axi_bready);
  wire ar_d      = ar_q ? !s_axi_rready : s_axi_arvalid;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      if (be[i]) old[i*8 +: 8] = nw[i*8 +: 8];
    return old;
  endfunction

  function automatic logic is_match(input logic [7:0] a);
    return (a[7:5] == ADDR_MATCH0[7:5]) && (a[4:2] < 3'(NUM_MATCH));
  endfunction

  wire [2:0] w_idx   = wa[4:2];
  wire [2:0] r_idx   = s_axi_araddr[4:2];
  wire       w_match = is_match(wa);
  wire       r_match = is_match(s_axi_araddr);
  wire w_known = w_match || wa inside {ADDR_CTRL, ADDR_PRESCALE, ADDR_PRECOUNT, ADDR_COUNT,
                 ADDR_MATCHCTL, ADDR_OUTCTL, ADDR_RELEASE, ADDR_INTSTAT, ADDR_INTMASK};

  // Timer core
  wire running  = ctrl_q[CTRL_RUN_BIT] && !ctrl_q[CTRL_RESET_BIT];
  wire pwm_mode = ctrl_q[CTRL_PWM_BIT];
  wire tick     = running && (precnt_q == prescale_q);
  logic [NUM_MATCH-1:0] hit;
  genvar g;
  generate
    for (g = 0; g < NUM_MATCH; g++)
    begin : g_hit
      assign hit[g] = tick && (count_q == active_q[g]);
    end
  endgenerate
  logic any_reset, any_stop;
  always_comb
  begin
    any_reset = 1'b0;
    any_stop  = 1'b0;
    for (int i = 0; i < NUM_MATCH; i++)
    begin
      any_reset |= hit[i] && matchctl_q[3*i+MC_RESET];
      any_stop  |= hit[i] && matchctl_q[3*i+MC_STOP];
    end
    // Cycle match always closes the cycle in modulator mode
    if (pwm_mode && hit[0])
      any_reset = 1'b1;
  end
  wire cycle_start = any_reset;
  wire load_ok     = !pwm_mode || (tick && cycle_start) || !running;
  logic [NUM_MATCH-1:0] irq_ev;
  generate
    for (g = 0; g < NUM_MATCH; g++)
    begin : g_ev
      assign irq_ev[g] = hit[g] && matchctl_q[3*g+MC_IRQ];
    end
  endgenerate
  // Set wins over write-one-to-clear
  wire                 wr_istat = do_wr && (wa == ADDR_INTSTAT);
  wire                 wr_imask = do_wr && (wa == ADDR_INTMASK);
  wire [NUM_MATCH-1:0] istat_d  = (wr_istat ? istat_q & ~wdata_q[NUM_MATCH-1:0] : istat_q)
                                  | irq_ev;
  wire [NUM_MATCH-1:0] imask_d  = wr_imask ? wdata_q[NUM_MATCH-1:0] : imask_q;

  // PWM edge logic
  logic [NUM_OUT:1] pwm_d;
  always_comb
  begin
    pwm_d = pwm_q;
    for (int n = 1; n <= NUM_OUT; n++)
    begin
      if (!pwm_mode || !outctl_q[OC_EN_LSB+n-1])
        pwm_d[n] = 1'b0;
      else if (outctl_q[OC_DBL_LSB+n-1] && n >= 2)
      begin
        // Rise on match n-1, fall on match n; fall wins on a tie
        if (hit[n-1])
          pwm_d[n] = 1'b1;
        if (hit[n])
          pwm_d[n] = 1'b0;
      end
      else
      begin
        // Fall match at or past period keeps the output high; zero keeps it low
        if (hit[0] && active_q[n] != RST_ZERO)
          pwm_d[n] = 1'b1;
        if (hit[n] && !hit[0])
          pwm_d[n] = 1'b0;
      end
    end
  end

  wire [31:0] precnt_d = tick ? RST_ZERO : (running ? precnt_q + 32'h1 : precnt_q);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      precnt_q <= RST_ZERO;
      count_q  <= RST_ZERO;
      pwm_q    <= '0;
      for (int i = 0; i < NUM_MATCH; i++)
        active_q[i] <= RST_ZERO;
    end
    else
    begin
      precnt_q <= ctrl_q[CTRL_RESET_BIT] ? RST_ZERO : precnt_d;
      if (ctrl_q[CTRL_RESET_BIT] || (tick && cycle_start))
        count_q <= RST_ZERO;
      // Stop holds the count at the matched value
      else if (tick && !any_stop)
        count_q <= count_q + 32'h1;
      pwm_q <= pwm_d;
      for (int i = 0; i < NUM_MATCH; i++)
        if (release_q[i] && load_ok)
          active_q[i] <= shadow_q[i];
    end
  end

  // Register bus
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_q       <= '0;
      w_have_q   <= 1'b0;
      wdata_q    <= RST_ZERO;
      wstrb_q    <= 4'h0;
      b_q        <= 1'b0;
      bresp_q    <= RESP_OKAY;
      ar_q       <= 1'b0;
      rdata_q    <= RST_ZERO;
      rresp_q    <= RESP_OKAY;
      ctrl_q     <= RST_ZERO;
      prescale_q <= RST_ZERO;
      matchctl_q <= RST_ZERO;
      outctl_q   <= RST_ZERO;
      release_q  <= '0;
      istat_q    <= '0;
      imask_q    <= '0;
      irq        <= 1'b0;
      awrdy_q    <= 1'b1;
      wrdy_q     <= 1'b1;
      arrdy_q    <= 1'b1;
      for (int i = 0; i < NUM_MATCH; i++)
        shadow_q[i] <= RST_ZERO;
    end
    else
    begin
      awrdy_q <= !aw_busy_d && !b_d;
      wrdy_q  <= !w_busy_d && !b_d;
      arrdy_q <= !ar_d;
      if (take_aw)
        aw_q <= '{valid: 1'b1, addr: s_axi_awaddr};
      if (take_w)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (b_q && s_axi_bready)
        b_q <= 1'b0;
      // Released values are consumed once loaded: at the cycle boundary while modulating, else at once
      for (int i = 0; i < NUM_MATCH; i++)
        if (release_q[i] && load_ok)
          release_q[i] <= 1'b0;
      if (any_stop)
        ctrl_q[CTRL_RUN_BIT] <= 1'b0;
      if (do_wr)
      begin
        aw_q.valid <= 1'b0;
        w_have_q   <= 1'b0;
        b_q        <= 1'b1;
        bresp_q    <= w_known ? RESP_OKAY : RESP_SLVERR;
        if (w_match)
          shadow_q[w_idx] <= merge(shadow_q[w_idx], wdata_q, wstrb_q);
        unique case (wa)
          ADDR_CTRL:     ctrl_q     <= merge(ctrl_q, wdata_q, wstrb_q);
          ADDR_PRESCALE: prescale_q <= merge(prescale_q, wdata_q, wstrb_q);
          ADDR_MATCHCTL: matchctl_q <= merge(matchctl_q, wdata_q, wstrb_q);
          ADDR_OUTCTL:   outctl_q   <= merge(outctl_q, wdata_q, wstrb_q);
          // Bits consumed this cycle must not survive a release write
          ADDR_RELEASE:  release_q  <= (load_ok ? '0 : release_q) | wdata_q[NUM_MATCH-1:0];
          ADDR_INTMASK:  imask_q    <= wdata_q[NUM_MATCH-1:0];
          default:       ;
        endcase
      end
      istat_q <= istat_d;
      // Built from next status and mask so it drops with the clearing write
      irq     <= |(istat_d & imask_d);
      if (ar_q && s_axi_rready)
        ar_q <= 1'b0;
      else if (s_axi_arvalid && !ar_q)
      begin
        ar_q    <= 1'b1;
        rresp_q <= RESP_OKAY;
        if (r_match)
          rdata_q <= active_q[r_idx];
        else
          unique case (s_axi_araddr)
            ADDR_CTRL:     rdata_q <= ctrl_q;
            ADDR_PRESCALE: rdata_q <= prescale_q;
            ADDR_PRECOUNT: rdata_q <= precnt_q;
            ADDR_COUNT:    rdata_q <= count_q;
            ADDR_MATCHCTL: rdata_q <= matchctl_q;
            ADDR_OUTCTL:   rdata_q <= outctl_q;
            ADDR_RELEASE:  rdata_q <= {25'h0, release_q};
            ADDR_INTSTAT:  rdata_q <= {25'h0, istat_q};
            ADDR_INTMASK:  rdata_q <= {25'h0, imask_q};
            default:
            begin
              rdata_q <= RST_ZERO;
              rresp_q <= RESP_SLVERR;
            end
          endcase
      end
    end
  end

  assign s_axi_awready = awrdy_q;
  assign s_axi_wready  = wrdy_q;
  assign s_axi_bvalid  = b_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arrdy_q;
  assign s_axi_rvalid  = ar_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign pwm_out       = pwm_q;

  // Checks
  chk_prescale_restart: assert property (@(posedge core_clk) disable iff (!resetn)
    tick && !ctrl_q[CTRL_RESET_BIT] |=> precnt_q == RST_ZERO)
    else $error("prescaler did not restart");
  chk_count_advance: assert property (@(posedge core_clk) disable iff (!resetn)
    tick && !cycle_start && !any_stop && !ctrl_q[CTRL_RESET_BIT]
      |=> count_q == $past(count_q) + 32'h1)
    else $error("counter did not advance");
  chk_cycle_reset: assert property (@(posedge core_clk) disable iff (!resetn)
    pwm_mode && hit[0] |=> count_q == RST_ZERO)
    else $error("cycle match did not reset count");
  chk_mode_off_low: assert property (@(posedge core_clk) disable iff (!resetn)
    !pwm_mode |=> pwm_out == '0)
    else $error("output driven outside modulator mode");
  chk_stop_match: assert property (@(posedge core_clk) disable iff (!resetn)
    any_stop |=> !ctrl_q[CTRL_RUN_BIT])
    else $error("stop on match ignored");
  chk_hold_unreleased: assert property (@(posedge core_clk) disable iff (!resetn)
    !release_q[1] |=> active_q[1] == $past(active_q[1]))
    else $error("match changed without release");
  chk_single_rise: assert property (@(posedge core_clk) disable iff (!resetn)
    pwm_mode && outctl_q[OC_EN_LSB] && !outctl_q[OC_DBL_LSB] && hit[0]
      && active_q[1] != RST_ZERO |=> pwm_out[1])
    else $error("single-edge output missed cycle rise");
  chk_const_low: assert property (@(posedge core_clk) disable iff (!resetn)
    pwm_mode && !outctl_q[OC_DBL_LSB+1] && active_q[2] == RST_ZERO && !pwm_out[2]
      |=> !pwm_out[2])
    else $error("constant-low output raised");
  chk_double_fall: assert property (@(posedge core_clk) disable iff (!resetn)
    pwm_mode && outctl_q[OC_EN_LSB+3] && outctl_q[OC_DBL_LSB+3] && hit[4] |=> !pwm_out[4])
    else $error("double-edge output missed fall");
  chk_irq_level: assert property (@(posedge core_clk) disable iff (!resetn)
    irq == |(istat_q & imask_q))
    else $error("masked status did not raise interrupt");
endmodule : mpt_timer
`default_nettype wire

// ### tb/mpt_timer_tb.sv
// Self-checking bench for the multi-channel PWM timer
`timescale 1ns/10ps
`default_nettype none
module mpt_timer_tb;
  import mpt_pkg::*;
  logic              core_clk, resetn;
  logic [7:0]        awaddr, araddr;
  logic              awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid, irq;
  logic [31:0]       wdata, rdata, rd;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, resp;
  logic [NUM_OUT:1]  pwm_out;
  int                failures, cmp_count, per, hi, hi2, tg, n, ch;

  mpt_timer mpt_timer_i (
    .core_clk(core_clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwm_out(pwm_out), .irq(irq)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Address and data offered together; each dropped once its own ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!(bvalid && bready) && k < 100);
    if (k >= 100) failures++;
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    int k;
    @(posedge core_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!(rvalid && rready) && k < 100);
    if (k >= 100) failures++;
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // One full output period from a rising edge: length and high cycles
  task automatic meas(input int c);
    logic low_seen;
    for (n = 0; n < 300 && pwm_out[c] !== 1'b0; n++) @(posedge core_clk);
    for (n = 0; n < 300 && pwm_out[c] !== 1'b1; n++) @(posedge core_clk);
    per = 0;
    hi = 0;
    low_seen = 1'b0;
    do
    begin
      hi += int'(pwm_out[c] === 1'b1);
      per++;
      @(posedge core_clk);
      if (pwm_out[c] === 1'b0) low_seen = 1'b1;
    end
    while (!(low_seen && pwm_out[c] === 1'b1) && per < 300);
  endtask

  task automatic cnt_hi(input int c, input int cyc);
    logic last;
    hi = 0;
    tg = 0;
    last = pwm_out[c];
    repeat (cyc)
    begin
      @(posedge core_clk);
      hi += int'(pwm_out[c] === 1'b1);
      tg += int'(pwm_out[c] !== last);
      last = pwm_out[c];
    end
  endtask

  task automatic endt(input string s);
    $display("test %s finished", s);
  endtask

  // Whole run is under a thousand cycles; generous margin
  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    close_out();
  end

  initial
  begin
    {resetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, failures, cmp_count} = '0;
    wstrb = 4'hf;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    rdr(ADDR_CTRL, rd);
    chk(rd, RST_ZERO);
    chk(32'(resp), 32'(RESP_OKAY));
    rdr(ADDR_COUNT, rd);
    chk(rd, RST_ZERO);
    rdr(8'h30, rd);
    chk(rd, RST_ZERO);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(8'h30, 32'h1234_5678);
    chk(32'(resp), 32'(RESP_SLVERR));
    endt("reset and map");
    wr(ADDR_MATCH0, 32'h5);
    wr(ADDR_MATCHCTL, 32'h5);
    wr(ADDR_RELEASE, 32'h1);
    wr(ADDR_CTRL, 32'h1);
    for (ch = 0; ch < 30; ch++)
    begin
      rdr(ADDR_CTRL, rd);
      if (rd[CTRL_RUN_BIT] === 1'b0) break;
    end
    chk(32'(rd[CTRL_RUN_BIT]), 32'h0);
    rdr(ADDR_COUNT, rd);
    chk(rd, 32'h5);
    rdr(ADDR_INTSTAT, rd);
    chk(rd, 32'h1);
    chk(32'(irq), 32'h0);
    wr(ADDR_INTMASK, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h1);
    wr(ADDR_INTSTAT, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h0);
    endt("stop and interrupt");
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_MATCHCTL, 32'h2);
    wr(ADDR_MATCH0, 32'h9);
    wr(ADDR_MATCH0 + 8'h04, 32'h4);
    wr(ADDR_MATCH0 + 8'h08, 32'h0);
    wr(ADDR_RELEASE, 32'h7f);
    wr(ADDR_OUTCTL, 32'h7e00);
    wr(ADDR_CTRL, 32'h5);
    meas(1);
    chk(per, 32'd10);
    hi2 = hi;
    cnt_hi(2, 40);
    chk(hi, 32'd0);
    wr(ADDR_MATCH0 + 8'h04, 32'h7);
    meas(1);
    chk(hi, hi2);
    wr(ADDR_RELEASE, 32'h2);
    meas(1);
    meas(1);
    chk(hi, hi2 + 3);
    wr(ADDR_PRESCALE, 32'h1);
    meas(1);
    meas(1);
    chk(per, 32'd20);
    endt("single edge");
    wr(ADDR_PRESCALE, 32'h0);
    wr(ADDR_MATCH0 + 8'h0c, 32'h2);
    wr(ADDR_MATCH0 + 8'h10, 32'h6);
    wr(ADDR_RELEASE, 32'h18);
    wr(ADDR_OUTCTL, 32'h7e10);
    meas(4);
    meas(4);
    chk(per, 32'd10);
    hi2 = hi;
    wr(ADDR_MATCH0 + 8'h0c, 32'h6);
    wr(ADDR_MATCH0 + 8'h10, 32'h2);
    wr(ADDR_RELEASE, 32'h18);
    meas(4);
    meas(4);
    chk(hi + hi2, 32'd10);
    endt("double edge");
    wr(ADDR_CTRL, 32'h1);
    // Last modulated level drains out first
    repeat (2) @(posedge core_clk);
    for (ch = 1; ch <= NUM_OUT; ch++)
    begin
      cnt_hi(ch, 12);
      chk(tg, 32'd0);
      chk(hi, 32'd0);
    end
    rdr(ADDR_COUNT, rd);
    chk(32'(rd < 32'd10), 32'h1);
    endt("plain timer");
    close_out();
  end
endmodule // mpt_timer_tb
`default_nettype wire
